/* File: design/tuec_top.sv */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Abort client transactions that consumed errors
// - Report consumed errors and pulse recovery interrupt
// - With error records, report external errors as events
// - Without error records, external error aborts access
// - Fault events go to transaction's security queue
// - Walk error records walk external-abort event
// - Stream entry fetch error records fetch event
// - Descriptor fetch error records descriptor fetch event
// - Command fetch error sets flag and code
// - Page-request queue abort sets its flag
// - Event queue abort sets its flag
// - Permission lookup error sets flag, fault code
// - Lost internal consistency enters service failure
// - Service failure terminates clients, stops queues
// - Service failure answers PCIe with completer abort
// - Registers stay readable during service failure
// - Reset or recovery input leaves service failure
// - Entry sets failure flag in both registers
// - Entry pulses notification interrupt with syndrome
// - Isolated partition errors never enter service failure
// - Failure interrupt is a single-cycle pulse; recovery interrupt stays high for each cycle an error is consumed outside service failure
module tuec_top #(
  parameter bit RAS_IMPL = 1'b1,
  parameter bit SECURE_IMPL = 1'b1,
  parameter logic [tuec_pkg::EVT_W-1:0] WALK_EVT_CODE = 8'h01,
  parameter logic [tuec_pkg::EVT_W-1:0] STE_EVT_CODE = 8'h02,
  parameter logic [tuec_pkg::EVT_W-1:0] CD_EVT_CODE = 8'h03,
  parameter logic [tuec_pkg::CONS_W-1:0] CMD_ABORT_CODE = 7'h02,
  parameter logic [tuec_pkg::FAR_CODE_W-1:0] DPT_ABORT_CODE = 4'h1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tuec_pkg::ADDR_W-1:0] paddr,
  input wire logic [tuec_pkg::DATA_W-1:0] pwdata,
  output logic [tuec_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Client transaction request
  input wire logic cli_valid,
  input wire logic cli_secure,
  input wire logic cli_pcie,
  input wire logic cli_err,
  input wire logic cli_ext_err,
  // Client transaction response
  output logic rsp_valid,
  output tuec_pkg::tuec_rsp_type rsp_status,
  output logic ext_abort,
  // Consumed errors from walks and fetches
  input wire logic walk_err,
  input wire logic walk_secure,
  input wire logic ste_fetch_err,
  input wire logic ste_secure,
  input wire logic cd_fetch_err,
  input wire logic cd_secure,
  input wire logic cmdq_fetch_err,
  input wire logic cmdq_secure,
  input wire logic priq_abort_err,
  input wire logic priq_secure,
  input wire logic evtq_abort_err,
  input wire logic evtq_secure,
  input wire logic dpt_lookup_err,
  input wire logic [tuec_pkg::FAR_ADDR_W-1:0] dpt_fault_addr,
  // Internal consistency
  input wire logic internal_ue,
  input wire logic internal_ue_isolated,
  input wire logic consistency_lost,
  input wire logic sfm_recover,
  // Event queue writer
  output logic evt_valid,
  input wire logic evt_ready,
  output logic evt_secure,
  output logic [tuec_pkg::EVT_W-1:0] evt_code,
  // Queue access permission
  output logic queue_access_en,
  // Error record reporting
  output logic ras_event,
  output logic [tuec_pkg::SYN_W-1:0] ras_syndrome,
  // Interrupt pulses
  output logic err_recovery_irq,
  output logic sfm_irq
);
  import tuec_pkg::*;

  function automatic tuec_rsp_type abort_kind(input logic pcie);
    abort_kind = pcie ? RSP_CA : RSP_ABORT;
  endfunction

  function automatic logic [GERR_W-1:0] gbit(input int pos, input logic on);
    gbit = on ? (GERR_W'(1) << pos) : GERR_W'(0);
  endfunction

  tuec_mode_type mode_q;
  tuec_mode_type mode_d;
  logic [GERR_W-1:0] gerr_ns_q;
  logic [GERR_W-1:0] gerr_ns_d;
  logic [GERR_W-1:0] gerr_s_q;
  logic [GERR_W-1:0] gerr_s_d;
  logic [CONS_W-1:0] cons_ns_q;
  logic [CONS_W-1:0] cons_s_q;
  logic [FAR_ADDR_W-1:0] far_addr_q;
  logic [FAR_CODE_W-1:0] far_code_q;
  logic [SYN_W-1:0] syn_q;
  logic iso_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [DATA_W-1:0] rdata_q;
  logic walk_pend_q;
  logic walk_sec_q;
  logic ste_pend_q;
  logic ste_sec_q;
  logic cd_pend_q;
  logic cd_sec_q;

  // Bus decode
  wire logic bus_setup = psel && !penable;
  wire logic bus_access = psel && penable;
  wire logic sel_gerr_ns = paddr == OFS_GERR_NS;
  wire logic sel_gerr_s = paddr == OFS_GERR_S;
  wire logic sel_cons_ns = paddr == OFS_CONS_NS;
  wire logic sel_cons_s = paddr == OFS_CONS_S;
  wire logic sel_far = paddr == OFS_DPT_FAR;
  wire logic sel_status = paddr == OFS_STATUS;
  wire logic sel_ctrl = paddr == OFS_CTRL;
  wire logic addr_hit = sel_gerr_ns || sel_gerr_s || sel_cons_ns || sel_cons_s ||
    sel_far || sel_status || sel_ctrl;
  wire logic wr_en = bus_access && pwrite && addr_hit;
  wire logic in_sfm = mode_q == MODE_SFM;

  // Service failure entry
  // entry condition
  wire logic sfm_cause = consistency_lost || (internal_ue && !internal_ue_isolated);
  wire logic sfm_enter = !in_sfm && sfm_cause;
  wire logic [SYN_W-1:0] syn_new = consistency_lost ? SYN_LOST : SYN_INT_UE;

  // Event sources suppressed once failure mode has stopped queue traffic
  wire logic run = !in_sfm;
  wire logic walk_set = run && walk_err;
  wire logic ste_set = run && ste_fetch_err;
  wire logic cd_set = run && cd_fetch_err;

  // Event queue arbitration, walk first
  wire logic walk_go = walk_pend_q && run;
  wire logic ste_go = ste_pend_q && run && !walk_pend_q;
  wire logic cd_go = cd_pend_q && run && !walk_pend_q && !ste_pend_q;
  wire logic walk_pop = walk_go && evt_ready;
  wire logic ste_pop = ste_go && evt_ready;
  wire logic cd_pop = cd_go && evt_ready;

  // Global error set terms per security state
  // global flags
  wire logic [GERR_W-1:0] set_ns = gbit(GB_CMDQ, cmdq_fetch_err && !cmdq_secure) |
    gbit(GB_PRIQ, priq_abort_err && !priq_secure) |
    gbit(GB_EVTQ, evtq_abort_err && !evtq_secure) |
    gbit(GB_DPT, dpt_lookup_err) |
    gbit(GB_SFM, sfm_enter);
  // failure flag in secure register too
  wire logic [GERR_W-1:0] set_s_raw = gbit(GB_CMDQ, cmdq_fetch_err && cmdq_secure) |
    gbit(GB_PRIQ, priq_abort_err && priq_secure) |
    gbit(GB_EVTQ, evtq_abort_err && evtq_secure) |
    gbit(GB_SFM, sfm_enter);
  wire logic [GERR_W-1:0] set_s = SECURE_IMPL ? set_s_raw : GERR_W'(0);

  // Write-one-to-clear, failure flag protected
  // sticky failure flag
  wire logic [GERR_W-1:0] clr_mask = pwdata[GERR_W-1:0] & ~gbit(GB_SFM, 1'b1);
  wire logic [GERR_W-1:0] clr_ns = (wr_en && sel_gerr_ns) ? clr_mask : GERR_W'(0);
  wire logic [GERR_W-1:0] clr_s = (wr_en && sel_gerr_s && SECURE_IMPL) ? clr_mask :
    GERR_W'(0);
  wire logic [GERR_W-1:0] keep_sfm = gbit(GB_SFM, !sfm_recover);

  // Any consumed error, used for reporting
  wire logic ext_consumed = walk_err || ste_fetch_err || cd_fetch_err || cmdq_fetch_err ||
    priq_abort_err || evtq_abort_err || dpt_lookup_err || (cli_valid && cli_ext_err);
  wire logic any_consumed = ext_consumed || (cli_valid && cli_err) || internal_ue;

  // Client response status
  // terminate or abort
  wire logic cli_kill = in_sfm || cli_err || cli_ext_err;
  wire tuec_rsp_type rsp_next = cli_kill ? abort_kind(cli_pcie) : RSP_OK;

  // Read data mux
  wire logic [DATA_W-1:0] rd_gerr_ns = {{(DATA_W-GERR_W){1'b0}}, gerr_ns_q};
  wire logic [DATA_W-1:0] rd_gerr_s = {{(DATA_W-GERR_W){1'b0}}, gerr_s_q};
  wire logic [DATA_W-1:0] rd_cons_ns = {1'b0, cons_ns_q, {CONS_LSB{1'b0}}};
  wire logic [DATA_W-1:0] rd_cons_s = {1'b0, cons_s_q, {CONS_LSB{1'b0}}};
  wire logic [DATA_W-1:0] rd_far = {far_code_q, {(FAR_CODE_LSB-FAR_ADDR_W){1'b0}}, far_addr_q};
  wire logic [DATA_W-1:0] rd_status = {{(DATA_W-ST_SYN_LSB-SYN_W){1'b0}}, syn_q,
    {(ST_SYN_LSB-ST_ISO-1){1'b0}}, iso_q, in_sfm};
  wire logic [DATA_W-1:0] rd_ctrl = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
  wire logic [DATA_W-1:0] rd_mux = sel_gerr_ns ? rd_gerr_ns :
    sel_gerr_s ? (SECURE_IMPL ? rd_gerr_s : DATA_W'(0)) :
    sel_cons_ns ? rd_cons_ns :
    sel_cons_s ? (SECURE_IMPL ? rd_cons_s : DATA_W'(0)) :
    sel_far ? rd_far :
    sel_status ? rd_status :
    sel_ctrl ? rd_ctrl : DATA_W'(0);

  // Next values
  // recovery input leaves failure mode
  assign mode_d = sfm_enter ? MODE_SFM : (sfm_recover ? MODE_NORMAL : mode_q);
  assign gerr_ns_d = ((gerr_ns_q & ~clr_ns) & (~gbit(GB_SFM, 1'b1) | keep_sfm)) | set_ns;
  assign gerr_s_d = ((gerr_s_q & ~clr_s) & (~gbit(GB_SFM, 1'b1) | keep_sfm)) | set_s;

  // APB answers at once; data held in flip-flops
  assign pready = 1'b1;
  assign pslverr = bus_access && !addr_hit;
  assign prdata = rdata_q;

  // Event queue writer
  // no queue traffic in failure mode
  assign queue_access_en = run;
  assign evt_valid = walk_go || ste_go || cd_go;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= MODE_NORMAL;
      gerr_ns_q <= GERR_RST;
      gerr_s_q <= GERR_RST;
    end
    else
    begin
      mode_q <= mode_d;
      gerr_ns_q <= gerr_ns_d;
      gerr_s_q <= gerr_s_d;
    end
  end

  // Command consumer error codes
  // abort code captured
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cons_ns_q <= CONS_RST;
      cons_s_q <= CONS_RST;
    end
    else if (cmdq_fetch_err)
    begin
      if (cmdq_secure && SECURE_IMPL)
        cons_s_q <= CMD_ABORT_CODE;
      else if (!cmdq_secure)
        cons_ns_q <= CMD_ABORT_CODE;
    end
  end

  // Permission table fault address
  // lookup abort code
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      far_addr_q <= '0;
      far_code_q <= '0;
    end
    else if (dpt_lookup_err)
    begin
      far_addr_q <= dpt_fault_addr;
      far_code_q <= DPT_ABORT_CODE;
    end
  end

  // Diagnosis state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syn_q <= SYN_NONE;
      iso_q <= 1'b0;
    end
    else
    begin
      if (sfm_enter)
        syn_q <= syn_new;
      if (internal_ue && internal_ue_isolated)
        iso_q <= 1'b1;
      else if (sfm_recover)
        iso_q <= 1'b0;
    end
  end

  // Control register and read data
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= CTRL_RST;
      rdata_q <= '0;
    end
    else
    begin
      if (wr_en && sel_ctrl)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (bus_setup && !pwrite)
        rdata_q <= rd_mux;
    end
  end

  // Pending fault events, set wins over issue
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      walk_pend_q <= 1'b0;
      ste_pend_q <= 1'b0;
      cd_pend_q <= 1'b0;
      walk_sec_q <= 1'b0;
      ste_sec_q <= 1'b0;
      cd_sec_q <= 1'b0;
    end
    else if (sfm_enter)
    begin
      walk_pend_q <= 1'b0;
      ste_pend_q <= 1'b0;
      cd_pend_q <= 1'b0;
    end
    else
    begin
      walk_pend_q <= walk_set || (walk_pend_q && !walk_pop);
      ste_pend_q <= ste_set || (ste_pend_q && !ste_pop);
      cd_pend_q <= cd_set || (cd_pend_q && !cd_pop);
      if (walk_set)
        walk_sec_q <= walk_secure && SECURE_IMPL;
      if (ste_set)
        ste_sec_q <= ste_secure && SECURE_IMPL;
      if (cd_set)
        cd_sec_q <= cd_secure && SECURE_IMPL;
    end
  end

  // Event record follows the highest-priority pending source
  always_comb
  begin
    evt_secure = 1'b0;
    evt_code = '0;
    if (walk_go)
    begin
      evt_secure = walk_sec_q;
      evt_code = WALK_EVT_CODE;
    end
    else if (ste_go)
    begin
      evt_secure = ste_sec_q;
      evt_code = STE_EVT_CODE;
    end
    else if (cd_go)
    begin
      evt_secure = cd_sec_q;
      evt_code = CD_EVT_CODE;
    end
  end

  // Client responses and reporting pulses
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp_status <= RSP_OK;
      ext_abort <= 1'b0;
      ras_event <= 1'b0;
      ras_syndrome <= SYN_NONE;
      err_recovery_irq <= 1'b0;
      sfm_irq <= 1'b0;
    end
    else
    begin
      rsp_valid <= cli_valid;
      rsp_status <= cli_valid ? rsp_next : RSP_OK;
      ext_abort <= !RAS_IMPL && cli_valid && cli_ext_err;
      ras_event <= RAS_IMPL && ctrl_q[CT_RAS_EN] && (ext_consumed || sfm_enter);
      if (RAS_IMPL && sfm_enter)
        ras_syndrome <= syn_new;
      err_recovery_irq <= ctrl_q[CT_IRQ_EN] && any_consumed && run;
      sfm_irq <= sfm_enter;
    end
  end

endmodule

/* File: design/tuec_pkg.sv */
package tuec_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_GERR_NS = 12'h000;
  localparam logic [11:0] OFS_GERR_S = 12'h004;
  localparam logic [11:0] OFS_CONS_NS = 12'h008;
  localparam logic [11:0] OFS_CONS_S = 12'h00C;
  localparam logic [11:0] OFS_DPT_FAR = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_CTRL = 12'h018;

  // Global error register layout
  localparam int GERR_W = 10;
  localparam int GB_CMDQ = 0;
  localparam int GB_EVTQ = 2;
  localparam int GB_PRIQ = 3;
  localparam int GB_SFM = 8;
  localparam int GB_DPT = 9;
  localparam logic [GERR_W-1:0] GERR_RST = 10'h000;

  // Command consumer error field
  localparam int CONS_LSB = 24;
  localparam int CONS_W = 7;
  localparam logic [CONS_W-1:0] CONS_RST = 7'h00;

  // Permission table fault address register layout
  localparam int FAR_ADDR_W = 24;
  localparam int FAR_CODE_LSB = 28;
  localparam int FAR_CODE_W = 4;

  // Status register layout
  localparam int ST_SFM = 0;
  localparam int ST_ISO = 1;
  localparam int ST_SYN_LSB = 4;
  localparam int SYN_W = 4;
  localparam logic [SYN_W-1:0] SYN_NONE = 4'h0;
  localparam logic [SYN_W-1:0] SYN_INT_UE = 4'h1;
  localparam logic [SYN_W-1:0] SYN_LOST = 4'h2;

  // Control register layout
  localparam int CT_IRQ_EN = 0;
  localparam int CT_RAS_EN = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;

  // Event code width
  localparam int EVT_W = 8;

  typedef enum logic [1:0] {
    RSP_OK = 2'b00,
    RSP_ABORT = 2'b01,
    RSP_CA = 2'b10
  } tuec_rsp_type;

  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_SFM = 1'b1
  } tuec_mode_type;

endpackage

/* File: dv/tuec_monitor.sv */
`timescale 1ns/1ps
module tuec_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Client side
  input wire logic cli_valid,
  input wire logic cli_pcie,
  input wire logic cli_err,
  input wire logic cli_ext_err,
  input wire logic rsp_valid,
  input wire tuec_pkg::tuec_rsp_type rsp_status,
  // Consistency and mode
  input wire logic internal_ue,
  input wire logic internal_ue_isolated,
  input wire logic consistency_lost,
  input wire logic sfm_recover,
  input wire logic queue_access_en,
  input wire logic sfm_irq,
  input wire logic err_recovery_irq,
  // Event queue
  input wire logic evt_valid,
  input wire logic evt_ready,
  input wire logic [tuec_pkg::EVT_W-1:0] evt_code
);
  import tuec_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire cause = consistency_lost || (internal_ue && !internal_ue_isolated);
  wire bad = cli_err || cli_ext_err || !queue_access_en;
  sequence enter_s;
    queue_access_en && cause;
  endsequence
  sequence failed_s;
    !queue_access_en && sfm_irq;
  endsequence
  rsp_timing_a:
  assert property (cli_valid |=> rsp_valid) else $error("no response");
  abort_status_a:
  assert property (cli_valid && bad && !cli_pcie |=> rsp_status == RSP_ABORT)
    else $error("not aborted");
  pcie_ca_a:
  assert property (cli_valid && bad && cli_pcie |=> rsp_status == RSP_CA)
    else $error("not completer abort");
  sfm_entry_a:
  assert property (enter_s |=> failed_s) else $error("no failure entry");
  sfm_sticky_a:
  assert property (!queue_access_en && !sfm_recover |=> !queue_access_en)
    else $error("failure mode left");
  sfm_exit_a:
  assert property (!queue_access_en && sfm_recover && !cause |=> queue_access_en)
    else $error("recovery ignored");
  iso_normal_a:
  assert property (queue_access_en && internal_ue && internal_ue_isolated
    && !consistency_lost |=> queue_access_en) else $error("isolated error entered");
  queue_stop_a:
  assert property (!queue_access_en |-> !evt_valid) else $error("queue written");
  evt_hold_a:
  assert property (evt_valid && !evt_ready && !cause |=> evt_valid && $stable(evt_code))
    else $error("event dropped");
  irq_pulse_a:
  assert property (sfm_irq |=> !sfm_irq) else $error("interrupt not a pulse");
  irq_gate_a:
  assert property (!queue_access_en |=> !err_recovery_irq)
    else $error("recovery interrupt in failure mode");
endmodule
bind tuec_top tuec_monitor u_mon (
  .sys_clk(sys_clk), .nrst(nrst), .cli_valid(cli_valid), .cli_pcie(cli_pcie),
  .cli_err(cli_err), .cli_ext_err(cli_ext_err), .rsp_valid(rsp_valid),
  .rsp_status(rsp_status), .internal_ue(internal_ue),
  .internal_ue_isolated(internal_ue_isolated), .consistency_lost(consistency_lost),
  .sfm_recover(sfm_recover), .queue_access_en(queue_access_en), .sfm_irq(sfm_irq),
  .err_recovery_irq(err_recovery_irq), .evt_valid(evt_valid), .evt_ready(evt_ready),
  .evt_code(evt_code)
);

/* File: dv/tuec_client_model.sv */
`timescale 1ns/1ps
module tuec_client_model (
  // Clock
  input wire logic sys_clk,
  // Transaction request
  output logic cli_valid,
  output logic cli_secure,
  output logic cli_pcie,
  output logic cli_err,
  output logic cli_ext_err,
  // Transaction response
  input wire logic rsp_valid,
  input wire tuec_pkg::tuec_rsp_type rsp_status,
  output tuec_pkg::tuec_rsp_type last_rsp
);
  import tuec_pkg::*;
  initial
  begin
    {cli_valid, cli_secure, cli_pcie, cli_err, cli_ext_err} = 5'h00;
    last_rsp = RSP_OK;
  end
  always @(posedge sys_clk)
    if (rsp_valid)
      last_rsp <= rsp_status;
  // Qualifiers flip once released so a stale value never passes
  task send(input logic e, input logic x, input logic p);
    @(posedge sys_clk);
    cli_valid <= 1'b1;
    {cli_err, cli_ext_err, cli_pcie} <= {e, x, p};
    cli_secure <= ~cli_secure;
    last_rsp <= tuec_rsp_type'(2'h3);
    @(posedge sys_clk);
    cli_valid <= 1'b0;
    {cli_err, cli_ext_err, cli_pcie} <= ~{e, x, p};
    @(posedge sys_clk);
    #1;
  endtask
endmodule

/* File: dv/translation_unit_error_containment_bench.sv */
`timescale 1ns/1ps
module translation_unit_error_containment_bench;
  import tuec_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, cli_valid, cli_secure, cli_pcie, cli_err, cli_ext_err;
  logic rsp_valid, ext_abort, evt_valid, evt_secure, queue_access_en;
  logic ras_event, err_recovery_irq, sfm_irq;
  logic evt_ready = 1'b0, sec = 1'b0, sfm_recover = 1'b0;
  tuec_rsp_type rsp_status, last_rsp;
  logic [EVT_W-1:0] evt_code;
  logic [SYN_W-1:0] ras_syndrome;
  logic [FAR_ADDR_W-1:0] dpt_fault_addr = 24'hABCDEF;
  logic [9:0] errs = 10'h000;
  logic walk_err, walk_secure, ste_fetch_err, ste_secure, cd_fetch_err, cd_secure;
  logic cmdq_fetch_err, cmdq_secure, priq_abort_err, priq_secure, evtq_abort_err;
  logic evtq_secure, dpt_lookup_err, internal_ue, internal_ue_isolated, consistency_lost;
  int failures = 0;
  int checked = 0;
  logic [7:0] ras_n = 8'h00, irq_n = 8'h00, sfm_n = 8'h00, abt_n = 8'h00;
  // Count one-cycle reporting pulses as they stand at each edge
  always @(posedge sys_clk)
  begin
    if (nrst)
    begin
      ras_n <= ras_n + 8'(ras_event);
      irq_n <= irq_n + 8'(err_recovery_irq);
      sfm_n <= sfm_n + 8'(sfm_irq);
      abt_n <= abt_n + 8'(ext_abort);
    end
  end
  assign {walk_err, ste_fetch_err, cd_fetch_err, cmdq_fetch_err, priq_abort_err,
    evtq_abort_err, dpt_lookup_err, internal_ue, internal_ue_isolated,
    consistency_lost} = errs;
  assign {walk_secure, ste_secure, cd_secure, cmdq_secure, priq_secure} = {5{sec}};
  assign evtq_secure = sec;
  always #2.5 sys_clk = ~sys_clk;
  tuec_top u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cli_valid(cli_valid), .cli_secure(cli_secure), .cli_pcie(cli_pcie), .cli_err(cli_err),
    .cli_ext_err(cli_ext_err), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .ext_abort(ext_abort), .walk_err(walk_err), .walk_secure(walk_secure),
    .ste_fetch_err(ste_fetch_err), .ste_secure(ste_secure), .cd_fetch_err(cd_fetch_err),
    .cd_secure(cd_secure), .cmdq_fetch_err(cmdq_fetch_err), .cmdq_secure(cmdq_secure),
    .priq_abort_err(priq_abort_err), .priq_secure(priq_secure),
    .evtq_abort_err(evtq_abort_err), .evtq_secure(evtq_secure),
    .dpt_lookup_err(dpt_lookup_err), .dpt_fault_addr(dpt_fault_addr),
    .internal_ue(internal_ue), .internal_ue_isolated(internal_ue_isolated),
    .consistency_lost(consistency_lost), .sfm_recover(sfm_recover),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_secure(evt_secure),
    .evt_code(evt_code), .queue_access_en(queue_access_en), .ras_event(ras_event),
    .ras_syndrome(ras_syndrome), .err_recovery_irq(err_recovery_irq), .sfm_irq(sfm_irq)
  );
  tuec_client_model u_cli (
    .sys_clk(sys_clk), .cli_valid(cli_valid), .cli_secure(cli_secure), .cli_pcie(cli_pcie),
    .cli_err(cli_err), .cli_ext_err(cli_ext_err), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status), .last_rsp(last_rsp)
  );
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task pulse(input logic [9:0] v, input logic s);
    @(posedge sys_clk);
    errs <= v;
    sec <= s;
    @(posedge sys_clk);
    errs <= 10'h000;
    #1;
  endtask
  task pop(input logic [7:0] c, input logic s);
    chk({evt_valid, evt_secure, evt_code}, {1'b1, s, c});
    @(posedge sys_clk);
    evt_ready <= 1'b1;
    @(posedge sys_clk);
    evt_ready <= 1'b0;
    #1;
  endtask
  task cli(input logic e, input logic x, input logic p, input tuec_rsp_type s);
    u_cli.send(e, x, p);
    chk(last_rsp, s);
  endtask
  task complete_run;
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    failures++;
    complete_run;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(OFS_CTRL, 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    cli(1'b0, 1'b0, 1'b1, RSP_OK);
    cli(1'b1, 1'b0, 1'b1, RSP_CA);
    cli(1'b1, 1'b0, 1'b0, RSP_ABORT);
    cli(1'b0, 1'b1, 1'b0, RSP_ABORT);
    chk({ras_n, irq_n, sfm_n, abt_n}, 32'h0103_0000);
    pulse(10'h200, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
    pop(8'h01, 1'b1);
    pulse(10'h180, 1'b0);
    pop(8'h02, 1'b0);
    pop(8'h03, 1'b0);
    chk(evt_valid, 1'b0);
    pulse(10'h040, 1'b0);
    rd(OFS_CONS_NS, 32'h0200_0000);
    pulse(10'h030, 1'b1);
    rd(OFS_GERR_S, 32'h0000_000C);
    pulse(10'h008, 1'b0);
    rd(OFS_GERR_NS, 32'h0000_0201);
    rd(OFS_DPT_FAR, 32'h10AB_CDEF);
    apb(1'b1, OFS_GERR_NS, 32'h0000_0201);
    apb(1'b1, OFS_GERR_S, 32'h0000_000C);
    rd(OFS_GERR_NS, 32'h0);
    rd(OFS_GERR_S, 32'h0);
    pulse(10'h006, 1'b0);
    rd(OFS_STATUS, 32'h0000_0002);
    pulse(10'h004, 1'b0);
    chk(queue_access_en, 1'b0);
    rd(OFS_STATUS, 32'h0000_0013);
    chk(ras_syndrome, SYN_INT_UE);
    rd(OFS_GERR_S, 32'h0000_0100);
    apb(1'b1, OFS_GERR_NS, 32'h0000_0100);
    rd(OFS_GERR_NS, 32'h0000_0100);
    cli(1'b0, 1'b0, 1'b1, RSP_CA);
    cli(1'b0, 1'b0, 1'b0, RSP_ABORT);
    pulse(10'h200, 1'b0);
    chk(evt_valid, 1'b0);
    @(posedge sys_clk);
    sfm_recover <= 1'b1;
    @(posedge sys_clk);
    sfm_recover <= 1'b0;
    #1;
    chk(queue_access_en, 1'b1);
    rd(OFS_GERR_S, 32'h0);
    pulse(10'h001, 1'b0);
    rd(OFS_STATUS, 32'h0000_0021);
    chk(ras_syndrome, SYN_LOST);
    apb(1'b1, OFS_CTRL, 32'h0);
    rd(OFS_CTRL, 32'h0);
    pulse(10'h040, 1'b0);
    chk({ras_n, irq_n, sfm_n, abt_n}, 32'h090A_0200);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_CTRL, 32'h3);
    complete_run;
  end
endmodule
